// [core/crd_card.sv]
// Notes on behaviour
// - commands carry class 90, params 00, Le 00
// - session start carries two identifier bytes, Lc 02
// - start answer gives header, code, partition length
// - partition and last decode chunk multiple of 8
// - encrypt only after start and centre steps; the card checks only that start was done
// - host chunks data, card returns encrypted chunks
// - encrypt command layout, Lc is L+6
// - chunks numbered from zero to m-1
// - final chunk field constant m-1 per transfer
// - full-size chunks except last, last not longer
// - answer echoes chunk number at offset 6
// - decode command Lc L+4, card returns decoded chunk
// - decode answer header, code, chunk, data
// - host closes session with identifier bytes, Lc 02
// - centre answer returns card to normal state
// - end answer carries chunk 00, final, upload data
`timescale 1ns/1ps
`default_nettype none
module crd_card (
  // clock and reset
  input  wire logic    clock,
  input  wire logic    resetn,
  // link to the receiver unit
  crd_link_if.card     link,
  // status
  output logic [1:0]   session,
  output logic [15:0]  last_rc,
  output logic [7:0]   chunk_count
);
  typedef enum logic {ST_RX, ST_TX} crd_st_e;
  crd_st_e        st;
  crd_pkg::crd_ses_e ses;
  logic [8:0]     idx;
  logic [7:0]     ins;
  logic [7:0]     lc;
  logic           fmt_ok;
  logic [7:0]     pdu;
  logic [7:0]     fin;
  logic [7:0]     fin_lock;
  logic [7:0]     enc_exp;
  logic [7:0]     dec_exp;
  logic [7:0]     chk;
  logic [7:0]     part_chk;
  logic [15:0]    rc;
  logic [7:0]     plen;
  logic [8:0]     tp;
  logic [7:0]     mem [crd_pkg::PART_MAX];
  logic           f_valid;
  logic [7:0]     f_data;
  logic           take;
  logic [7:0]     pre;
  logic [8:0]     k;
  logic [7:0]     clen;
  logic           last_byte;
  logic [15:0]    next_rc;
  logic [7:0]     next_plen;
  logic [7:0]     rsp_byte;
  logic [8:0]     rlen;
  logic [8:0]     q;

  // command bytes queue up while the answer is being sent
  crd_fifo #(.W(crd_pkg::FIFO_WIDTH), .D(crd_pkg::FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (link.h2c_valid),
    .in_data   (link.h2c_data),
    .in_ready  (link.h2c_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (take)
  );

  assign take      = f_valid && (st == ST_RX);
  assign pre       = crd_pkg::crd_pre_len(ins);
  assign k         = idx - crd_pkg::POS_DATA;
  assign clen      = lc - pre;
  assign last_byte = (idx > crd_pkg::POS_LC) && (idx == {1'b0, lc} + crd_pkg::POS_DATA);
  assign rlen      = 9'(crd_pkg::RSP_HDR) + 9'(plen) + 9'(crd_pkg::RSP_TAIL);
  assign q         = tp - 9'(crd_pkg::RSP_HDR);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st  <= ST_RX;
      idx <= '0;
    end else if (st == ST_RX) begin
      if (take) begin
        idx <= last_byte ? 9'h000 : idx + 9'h001;
        if (last_byte) st <= ST_TX;
      end
    end else if (tp == rlen && (!link.c2h_valid || link.c2h_ready)) begin
      st <= ST_RX;
    end
  end

  // field capture as the command streams in
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ins      <= 8'h00;
      lc       <= 8'h00;
      fmt_ok   <= 1'b0;
      pdu      <= 8'h00;
      fin      <= 8'h00;
      part_chk <= 8'h00;
    end else if (take) begin
      if (idx == 9'h000) begin
        fmt_ok   <= f_data == crd_pkg::CLA_CODE;
        part_chk <= 8'h00;
        pdu      <= 8'h00;
        fin      <= 8'h00;
      end else if (idx == 9'h001) begin
        ins <= f_data;
      end else if (idx < crd_pkg::POS_LC) begin
        if (f_data != crd_pkg::PARAM_ZERO) fmt_ok <= 1'b0;
      end else if (idx == crd_pkg::POS_LC) begin
        lc <= f_data;
      end else if (last_byte) begin
        if (f_data != crd_pkg::LE_ZERO) fmt_ok <= 1'b0;
      end else begin
        if (pre >= crd_pkg::PRE_DEC && k == 9'(pre - 8'h02)) pdu <= f_data;
        if (pre >= crd_pkg::PRE_DEC && k == 9'(pre - 8'h01)) fin <= f_data;
        if (k >= 9'(pre) && pre != 8'h00) part_chk <= part_chk ^ f_data ^ crd_pkg::CIPHER_KEY;
      end
    end
  end

  // chunk store holds the transformed bytes; overlong data is dropped
  always_ff @(posedge clock) begin
    if (take && !last_byte && idx > crd_pkg::POS_LC && pre >= crd_pkg::PRE_DEC
        && k >= 9'(pre) && (k - 9'(pre)) < 9'(crd_pkg::PART_MAX)) begin
      mem[6'(k - 9'(pre))] <= f_data ^ crd_pkg::CIPHER_KEY;
    end
  end

  // verdict on the completed command
  always_comb begin
    next_rc   = crd_pkg::RC_OK;
    next_plen = 8'h00;
    if (!fmt_ok || pre == 8'h00 || lc < pre) begin
      next_rc = crd_pkg::RC_CMD;
    end else if (ins == crd_pkg::INS_START || ins == crd_pkg::INS_END) begin
      if (lc != crd_pkg::PRE_ID) next_rc = crd_pkg::RC_CMD;
      else if (ins == crd_pkg::INS_END && ses != crd_pkg::SES_OPEN) next_rc = crd_pkg::RC_STATE;
      next_plen = (ins == crd_pkg::INS_START) ? crd_pkg::PL_START : crd_pkg::PL_END;
    end else if (ins == crd_pkg::INS_ENC || ins == crd_pkg::INS_DEC) begin
      next_plen = 8'h01;
      if (ses != crd_pkg::SES_OPEN) begin
        next_rc = crd_pkg::RC_STATE;
      end else if (pdu != ((ins == crd_pkg::INS_ENC) ? enc_exp : dec_exp) || pdu > fin
                   || (pdu != 8'h00 && fin != fin_lock)) begin
        next_rc = crd_pkg::RC_SEQ;
      end else if ({8'h00, clen} > crd_pkg::PART_LEN
                   || (pdu < fin && {8'h00, clen} != crd_pkg::PART_LEN)
                   || (ins == crd_pkg::INS_DEC && (clen[2:0] & crd_pkg::BLK_MASK) != 3'h0)) begin
        next_rc = crd_pkg::RC_LEN;
      end else begin
        next_plen = clen + 8'h01;
      end
    end
  end

  // session bookkeeping; only accepted commands move it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ses      <= crd_pkg::SES_IDLE;
      rc       <= crd_pkg::RC_OK;
      plen     <= 8'h00;
      enc_exp  <= 8'h00;
      dec_exp  <= 8'h00;
      fin_lock <= 8'h00;
      chk      <= 8'h00;
      chunk_count <= 8'h00;
    end else if (take && last_byte) begin
      rc   <= next_rc;
      plen <= next_plen;
      if (next_rc == crd_pkg::RC_OK) begin
        if (ins == crd_pkg::INS_START) begin
          ses         <= crd_pkg::SES_OPEN;
          enc_exp     <= 8'h00;
          dec_exp     <= 8'h00;
          chk         <= 8'h00;
          chunk_count <= 8'h00;
        end else if (ins == crd_pkg::INS_ENC || ins == crd_pkg::INS_DEC) begin
          fin_lock <= fin;
          if (ins == crd_pkg::INS_ENC) begin
            enc_exp     <= (pdu == fin) ? 8'h00 : pdu + 8'h01;
            chk         <= chk ^ part_chk;
            chunk_count <= chunk_count + 8'h01;
          end else begin
            dec_exp <= (pdu == fin) ? 8'h00 : pdu + 8'h01;
          end
        end else if (ins == crd_pkg::INS_END) begin
          ses <= crd_pkg::SES_UPLOAD;
        end else if (ses == crd_pkg::SES_UPLOAD) begin
          ses <= crd_pkg::SES_IDLE;
        end
      end
    end
  end

  // answer bytes
  always_comb begin
    rsp_byte = crd_pkg::PUN_ZERO;
    if (tp == 9'h001) begin
      rsp_byte = plen + crd_pkg::RSP_HDR - 8'h02;
    end else if (tp == 9'h004) begin
      rsp_byte = rc[15:8];
    end else if (tp == 9'h005) begin
      rsp_byte = rc[7:0];
    end else if (tp >= 9'(crd_pkg::RSP_HDR) && q < 9'(plen)) begin
      if (ins == crd_pkg::INS_START) begin
        rsp_byte = (q == 9'h000) ? crd_pkg::PART_LEN[15:8] : crd_pkg::PART_LEN[7:0];
      end else if (ins == crd_pkg::INS_END) begin
        if (q == 9'h002) rsp_byte = chunk_count;
        else if (q == 9'h003) rsp_byte = chk;
      end else begin
        rsp_byte = (q == 9'h000) ? pdu : mem[6'(q - 9'h001)];
      end
    end else if (tp == 9'(crd_pkg::RSP_HDR) + 9'(plen)) begin
      rsp_byte = crd_pkg::SW1_OK;
    end else if (tp > 9'(crd_pkg::RSP_HDR) + 9'(plen)) begin
      rsp_byte = crd_pkg::SW2_OK;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tp             <= '0;
      link.c2h_valid <= 1'b0;
      link.c2h_data  <= 8'h00;
    end else if (st == ST_RX) begin
      tp <= '0;
    end else if (!link.c2h_valid || link.c2h_ready) begin
      link.c2h_valid <= tp < rlen;
      if (tp < rlen) begin
        link.c2h_data <= rsp_byte;
        tp            <= tp + 9'h001;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      session <= 2'h0;
      last_rc <= crd_pkg::RC_OK;
    end else begin
      session <= ses;
      last_rc <= rc;
    end
  end
endmodule : crd_card
`default_nettype wire

// [core/crd_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module crd_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic [AW:0]   next_cnt;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = cnt != '0;
  assign out_data  = mem[rp];
  assign next_cnt  = cnt + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clock) begin
    if (push) mem[wp] <= in_data;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wp       <= '0;
      rp       <= '0;
      cnt      <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
      if (pop) rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
      cnt      <= next_cnt;
      // registered ready, so never take a word into a full store
      in_ready <= next_cnt < (AW+1)'(D);
    end
  end
endmodule : crd_fifo
`default_nettype wire

// [core/crd_host.sv]
`timescale 1ns/1ps
`default_nettype none
module crd_host (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // link to the card
  crd_link_if.host         link,
  // operation request
  input  wire logic        op_valid,
  input  wire logic [7:0]  op_ins,
  input  wire logic [7:0]  group_id,
  input  wire logic [7:0]  centre_id,
  input  wire logic [15:0] total_len,
  output logic             op_ready,
  // payload in
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  output logic             in_ready,
  // result out
  output logic             out_valid,
  output logic [7:0]       out_data,
  output logic             done,
  output logic [15:0]      rc,
  output logic [15:0]      part_len
);
  typedef enum logic [1:0] {H_IDLE, H_CALC, H_SEND, H_RECV} crd_hst_e;
  crd_hst_e    st;
  logic [7:0]  ins;
  logic [7:0]  bg;
  logic [7:0]  cid;
  logic [15:0] tlen;
  logic [15:0] rem;
  logic [15:0] acc;
  logic [7:0]  pdu;
  logic [7:0]  fin;
  logic [7:0]  clen;
  logic [8:0]  sp;
  logic [8:0]  rp;
  logic [7:0]  ulen;
  logic        have;
  logic [7:0]  hb;
  logic [7:0]  pre;
  logic [8:0]  k;
  logic [8:0]  send_len;
  logic [7:0]  tx_byte;
  logic        need;
  logic        slot;
  logic        rx;
  logic [15:0] chunk;

  assign pre      = crd_pkg::crd_pre_len(ins);
  assign k        = sp - crd_pkg::POS_DATA;
  assign send_len = crd_pkg::POS_DATA + 9'(pre) + 9'(clen) + 9'h001;
  assign need     = sp >= crd_pkg::POS_DATA + 9'(pre) && sp < send_len - 9'h001;
  assign slot     = !link.h2c_valid || link.h2c_ready;
  assign rx       = link.c2h_valid && link.c2h_ready;
  assign chunk    = (rem > part_len) ? part_len : rem;

  always_comb begin
    tx_byte = crd_pkg::PARAM_ZERO;
    if (sp == 9'h000) tx_byte = crd_pkg::CLA_CODE;
    else if (sp == 9'h001) tx_byte = ins;
    else if (sp == crd_pkg::POS_LC) tx_byte = pre + clen;
    else if (need) tx_byte = hb;
    else if (sp > crd_pkg::POS_LC && ins != crd_pkg::INS_CTR && k < 9'(pre)) begin
      if (k == 9'h000) tx_byte = bg;
      else if (k == 9'h001) tx_byte = cid;
      else if (k == 9'(pre - 8'h02)) tx_byte = pdu;
      else if (k == 9'(pre - 8'h01)) tx_byte = fin;
      else if (k == 9'h002) tx_byte = tlen[15:8];
      else tx_byte = tlen[7:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= H_IDLE;
      op_ready <= 1'b0;
      ins <= 8'h00;
      bg <= 8'h00;
      cid <= 8'h00;
      tlen <= 16'h0000;
      rem <= 16'h0000;
      acc <= 16'h0000;
      pdu <= 8'h00;
      fin <= 8'h00;
      clen <= 8'h00;
      sp <= '0;
      rp <= '0;
      ulen <= 8'h00;
      have <= 1'b0;
      hb <= 8'h00;
      in_ready <= 1'b0;
      link.h2c_valid <= 1'b0;
      link.h2c_data <= 8'h00;
      link.c2h_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
      done <= 1'b0;
      rc <= crd_pkg::RC_OK;
      part_len <= crd_pkg::PART_LEN;
    end else begin
      done      <= 1'b0;
      out_valid <= 1'b0;
      op_ready  <= (st == H_IDLE) && !(op_valid && op_ready);
      case (st)
        H_IDLE: begin
          if (op_valid && op_ready) begin
            ins  <= op_ins;
            bg   <= group_id;
            cid  <= centre_id;
            tlen <= total_len;
            rem  <= total_len;
            pdu  <= 8'h00;
            fin  <= 8'h00;
            acc  <= part_len;
            sp   <= '0;
            st   <= H_CALC;
          end
        end
        H_CALC: begin
          // final chunk index by repeated addition, no divider
          if (ins != crd_pkg::INS_DEC && ins != crd_pkg::INS_ENC) begin
            clen <= (ins == crd_pkg::INS_CTR) ? tlen[7:0] : 8'h00;
            st   <= H_SEND;
          end else if (acc >= tlen) begin
            clen <= chunk[7:0];
            st   <= H_SEND;
          end else begin
            acc <= acc + part_len;
            fin <= fin + 8'h01;
          end
        end
        H_SEND: begin
          if (in_valid && in_ready) begin
            hb       <= in_data;
            have     <= 1'b1;
            in_ready <= 1'b0;
          end else begin
            in_ready <= need && !have && !(slot && need && have);
          end
          if (slot) begin
            if (sp < send_len && (!need || have)) begin
              link.h2c_valid <= 1'b1;
              link.h2c_data  <= tx_byte;
              sp             <= sp + 9'h001;
              if (need) have <= 1'b0;
            end else begin
              link.h2c_valid <= 1'b0;
              if (sp == send_len) begin
                st             <= H_RECV;
                rp             <= '0;
                link.c2h_ready <= 1'b1;
                in_ready       <= 1'b0;
              end
            end
          end
        end
        H_RECV: begin
          if (rx) begin
            rp <= rp + 9'h001;
            if (rp == 9'h001) ulen <= link.c2h_data;
            if (rp == 9'h004) rc[15:8] <= link.c2h_data;
            if (rp == 9'h005) rc[7:0] <= link.c2h_data;
            if (ins == crd_pkg::INS_START && rp == 9'h006) part_len[15:8] <= link.c2h_data;
            if (ins == crd_pkg::INS_START && rp == 9'h007) part_len[7:0] <= link.c2h_data;
            if (rp > 9'h001 && rp < 9'(ulen) + 9'h002) begin
              out_valid <= rp >= ((pre >= crd_pkg::PRE_DEC) ? 9'h007 : 9'h006);
              out_data  <= link.c2h_data;
            end
            if (rp > 9'h001 && rp == 9'(ulen) + 9'h003) begin
              link.c2h_ready <= 1'b0;
              sp             <= '0;
              if (pre >= crd_pkg::PRE_DEC && rc == crd_pkg::RC_OK && pdu < fin) begin
                pdu  <= pdu + 8'h01;
                rem  <= rem - {8'h00, clen};
                clen <= (rem - {8'h00, clen} > part_len) ? part_len[7:0] : 8'(rem - {8'h00, clen});
                st   <= H_SEND;
              end else begin
                done <= 1'b1;
                st   <= H_IDLE;
              end
            end
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end
endmodule : crd_host
`default_nettype wire

// [core/crd_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface crd_link_if;
  logic       h2c_valid;
  logic [7:0] h2c_data;
  logic       h2c_ready;
  logic       c2h_valid;
  logic [7:0] c2h_data;
  logic       c2h_ready;
  modport card (input h2c_valid, h2c_data, c2h_ready, output h2c_ready, c2h_valid, c2h_data);
  modport host (output h2c_valid, h2c_data, c2h_ready, input h2c_ready, c2h_valid, c2h_data);
endinterface : crd_link_if
`default_nettype wire

// [core/crd_pkg.sv]
package crd_pkg;
  // apdu framing
  localparam logic [7:0] CLA_CODE   = 8'h90;
  localparam logic [7:0] PARAM_ZERO = 8'h00;
  localparam logic [7:0] LE_ZERO    = 8'h00;
  localparam logic [7:0] PUN_ZERO   = 8'h00;
  localparam logic [7:0] SW1_OK     = 8'h90;
  localparam logic [7:0] SW2_OK     = 8'h00;
  localparam logic [8:0] POS_LC     = 9'h004;
  localparam logic [8:0] POS_DATA   = 9'h005;
  // instruction codes of this command group
  localparam logic [7:0] INS_START  = 8'h52;
  localparam logic [7:0] INS_ENC    = 8'h54;
  localparam logic [7:0] INS_DEC    = 8'h56;
  localparam logic [7:0] INS_END    = 8'h58;
  localparam logic [7:0] INS_CTR    = 8'h46;
  // fixed prefix lengths ahead of the chunk bytes
  localparam logic [7:0] PRE_ID     = 8'h02;
  localparam logic [7:0] PRE_ENC    = 8'h06;
  localparam logic [7:0] PRE_DEC    = 8'h04;
  localparam logic [7:0] PRE_CTR    = 8'h01;
  // response layout
  localparam logic [7:0] RSP_HDR    = 8'h06;
  localparam logic [7:0] RSP_TAIL   = 8'h02;
  localparam logic [7:0] PL_START   = 8'h02;
  localparam logic [7:0] PL_END     = 8'h04;
  // partition size, a multiple of the cipher block
  localparam logic [15:0] PART_LEN  = 16'h0040;
  localparam int          PART_MAX  = 64;
  localparam logic [2:0]  BLK_MASK  = 3'h7;
  localparam logic [7:0]  CIPHER_KEY = 8'h5A;
  // return codes
  localparam logic [15:0] RC_OK     = 16'h0000;
  localparam logic [15:0] RC_CMD    = 16'hA101;
  localparam logic [15:0] RC_SEQ    = 16'hA102;
  localparam logic [15:0] RC_LEN    = 16'hA103;
  localparam logic [15:0] RC_STATE  = 16'hA104;
  localparam int          FIFO_DEPTH = 8;
  localparam int          FIFO_WIDTH = 8;

  typedef enum logic [1:0] {SES_IDLE, SES_OPEN, SES_UPLOAD} crd_ses_e;

  function automatic logic [7:0] crd_pre_len(input logic [7:0] ins);
    if (ins == INS_START || ins == INS_END) crd_pre_len = PRE_ID;
    else if (ins == INS_ENC) crd_pre_len = PRE_ENC;
    else if (ins == INS_DEC) crd_pre_len = PRE_DEC;
    else if (ins == INS_CTR) crd_pre_len = PRE_CTR;
    else crd_pre_len = 8'h00;
  endfunction : crd_pre_len
endpackage : crd_pkg

// [testbench/card_receiver_data_upload_cmds_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module card_receiver_data_upload_cmds_tb;
  logic        clock;
  logic        resetn;
  logic        op_valid;
  logic [7:0]  op_ins;
  logic [7:0]  group_id;
  logic [7:0]  centre_id;
  logic [15:0] total_len;
  logic        op_ready;
  logic        in_valid;
  logic [7:0]  in_data;
  logic        in_ready;
  logic        out_valid;
  logic [7:0]  out_data;
  logic        done;
  logic [15:0] rc;
  logic [15:0] part_len;
  logic [1:0]  session;
  logic [15:0] last_rc;
  logic [7:0]  chunk_count;
  logic [7:0]  exp_q[$];
  logic [7:0]  esum;
  logic [31:0] seed = 32'h58CCD5D8;
  logic        xq;
  int          checks;
  int          miscompares;
  int          cycles;
  int          hix;
  int          cix;
  logic [7:0]  wlc;
  logic [7:0]  wul;
  crd_link_if crd_link_if_inst ();
  crd_host crd_host_inst (.clock(clock), .resetn(resetn), .link(crd_link_if_inst),
    .op_valid(op_valid), .op_ins(op_ins), .group_id(group_id), .centre_id(centre_id),
    .total_len(total_len), .op_ready(op_ready), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .done(done), .rc(rc),
    .part_len(part_len));
  crd_card crd_card_inst (.clock(clock), .resetn(resetn), .link(crd_link_if_inst),
    .session(session), .last_rc(last_rc), .chunk_count(chunk_count));
  crd_assertions crd_assertions_inst (.clock(clock), .resetn(resetn),
    .h2c_valid(crd_link_if_inst.h2c_valid), .h2c_data(crd_link_if_inst.h2c_data),
    .h2c_ready(crd_link_if_inst.h2c_ready), .c2h_valid(crd_link_if_inst.c2h_valid),
    .c2h_data(crd_link_if_inst.c2h_data), .c2h_ready(crd_link_if_inst.c2h_ready));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // one operation; payload bytes come from the stalling feeder below
  task automatic run_op(input logic [7:0] ins, input logic [15:0] len, input logic x);
    int n;
    xq = x;
    op_ins = ins;
    total_len = len;
    op_valid = 1'b1;
    do @(posedge clock); while (op_ready !== 1'b1);
    #1 op_valid = 1'b0;
    n = 0;
    do begin @(posedge clock); n++; end while (done !== 1'b1 && n < 8000);
    `CHK(done, 1'b1)
    #1 `CHK(exp_q.size(), 0)
  endtask : run_op
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // payload feeder: random stalls, holds byte until taken
  always @(posedge clock) begin
    if (in_valid && in_ready && xq) exp_q.push_back(in_data ^ 8'h5A);
    if (in_valid && in_ready && xq && op_ins == crd_pkg::INS_ENC) esum = esum ^ in_data ^ 8'h5A;
    if (!in_valid || in_ready) begin
      #1 in_valid = rnd() > 32'h40000000;
      in_data = rnd();
    end
  end
  always @(posedge clock) begin
    if (out_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK(out_data, exp_q.pop_front())
    end
  end
  // wire framing seen directly on the link
  always @(posedge clock) begin
    if (crd_link_if_inst.h2c_valid && crd_link_if_inst.h2c_ready) begin
      if (hix == 0) `CHK(crd_link_if_inst.h2c_data, crd_pkg::CLA_CODE)
      if (hix == 2) `CHK(crd_link_if_inst.h2c_data, crd_pkg::PARAM_ZERO)
      if (hix == 4) wlc = crd_link_if_inst.h2c_data;
      if (hix > 4 && hix == wlc + 5) begin
        `CHK(crd_link_if_inst.h2c_data, crd_pkg::LE_ZERO)
        hix = 0;
      end else hix++;
    end
    if (crd_link_if_inst.c2h_valid && crd_link_if_inst.c2h_ready) begin
      if (cix == 0) `CHK(crd_link_if_inst.c2h_data, crd_pkg::PUN_ZERO)
      if (cix == 1) wul = crd_link_if_inst.c2h_data;
      if (cix > 1 && cix == wul + 3) begin
        `CHK(crd_link_if_inst.c2h_data, crd_pkg::SW2_OK)
        cix = 0;
      end else cix++;
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    resetn = 1'b0;
    op_valid = 1'b0;
    op_ins = 8'h00;
    total_len = 16'h0000;
    in_valid = 1'b0;
    in_data = 8'h00;
    xq = 1'b0;
    esum = 8'h00;
    group_id = rnd();
    centre_id = rnd();
    repeat (20) @(posedge clock);
    #1 resetn = 1'b1;
    @(posedge clock);
    #1 run_op(crd_pkg::INS_ENC, 16'h0008, 1'b0);
    `CHK(rc, crd_pkg::RC_STATE)
    `CHK(last_rc, crd_pkg::RC_STATE)
    exp_q.push_back(crd_pkg::PART_LEN[15:8]);
    exp_q.push_back(crd_pkg::PART_LEN[7:0]);
    run_op(crd_pkg::INS_START, 16'h0000, 1'b0);
    `CHK(part_len, crd_pkg::PART_LEN)
    `CHK(part_len[2:0], 3'h0)
    `CHK(session, 2'h1)
    run_op(crd_pkg::INS_CTR, 16'h0000, 1'b0);
    `CHK(rc, crd_pkg::RC_OK)
    run_op(crd_pkg::INS_ENC, 16'h0046, 1'b1);
    `CHK(rc, crd_pkg::RC_OK)
    `CHK(chunk_count, 8'h02)
    run_op(crd_pkg::INS_DEC, 16'h000C, 1'b0);
    `CHK(rc, crd_pkg::RC_LEN)
    run_op(crd_pkg::INS_DEC, 16'h0048, 1'b1);
    `CHK(rc, crd_pkg::RC_OK)
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h02);
    exp_q.push_back(esum);
    run_op(crd_pkg::INS_END, 16'h0000, 1'b0);
    `CHK(session, 2'h2)
    run_op(crd_pkg::INS_CTR, 16'h0003, 1'b0);
    `CHK(session, 2'h0)
    final_report();
  end
endmodule : card_receiver_data_upload_cmds_tb
`default_nettype wire

// [testbench/crd_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module crd_assertions (
  // clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // link between the two ends
  input wire logic       h2c_valid,
  input wire logic [7:0] h2c_data,
  input wire logic       h2c_ready,
  input wire logic       c2h_valid,
  input wire logic [7:0] c2h_data,
  input wire logic       c2h_ready
);
  logic [8:0] hi;
  logic [8:0] ci;
  logic [7:0] ins;
  logic [7:0] lc;
  logic [7:0] ul;
  logic [7:0] pdu;
  wire hf = h2c_valid & h2c_ready;
  wire cf = c2h_valid & c2h_ready;
  // lc only valid past byte 4, hence the guard on the end test
  wire h_end = hf && hi > 9'h004 && hi == {1'b0, lc} + 9'h005;
  wire c_end = cf && ci > 9'h001 && ci == {1'b0, ul} + 9'h003;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi <= '0;
      ins <= '0;
      lc <= '0;
      pdu <= '0;
    end else if (hf) begin
      hi <= h_end ? 9'h000 : hi + 9'h001;
      if (hi == 9'h001) ins <= h2c_data;
      if (hi == 9'h004) lc <= h2c_data;
      if ((ins == crd_pkg::INS_ENC && hi == 9'h009) || (ins == crd_pkg::INS_DEC && hi == 9'h007))
        pdu <= h2c_data;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ci <= '0;
      ul <= '0;
    end else if (cf) begin
      ci <= c_end ? 9'h000 : ci + 9'h001;
      if (ci == 9'h001) ul <= c2h_data;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_cla; hf && hi == 9'h000 |-> h2c_data == crd_pkg::CLA_CODE; endproperty
  a_cla: assert property (p_cla) else $error("class byte wrong");
  property p_par; hf && (hi == 9'h002 || hi == 9'h003) |-> h2c_data == 8'h00; endproperty
  a_par: assert property (p_par) else $error("parameter byte not zero");
  property p_le; h_end |-> h2c_data == crd_pkg::LE_ZERO; endproperty
  a_le: assert property (p_le) else $error("length byte not zero");
  property p_pun; cf && ci == 9'h000 |-> c2h_data == crd_pkg::PUN_ZERO; endproperty
  a_pun: assert property (p_pun) else $error("unit number not zero");
  property p_sw1; cf && ci > 9'h001 && ci == {1'b0, ul} + 9'h002 |-> c2h_data == 8'h90; endproperty
  a_sw1: assert property (p_sw1) else $error("status word wrong");
  property p_part; cf && ci == 9'h007 && ins == crd_pkg::INS_START |-> c2h_data[2:0] == 3'h0;
  endproperty
  a_part: assert property (p_part) else $error("partition not multiple of 8");
  property p_echo; cf && ci == 9'h006 && (ins == crd_pkg::INS_ENC || ins == crd_pkg::INS_DEC)
    |-> c2h_data == pdu; endproperty
  a_echo: assert property (p_echo) else $error("chunk number not echoed");
  property p_endpdu; cf && ci == 9'h006 && ins == crd_pkg::INS_END |-> c2h_data == 8'h00;
  endproperty
  a_endpdu: assert property (p_endpdu) else $error("end chunk number wrong");
  property p_enclen; hf && hi == 9'h004 && ins == crd_pkg::INS_ENC |-> h2c_data <= 8'h46;
  endproperty
  a_enclen: assert property (p_enclen) else $error("encrypt chunk too long");
  property p_declen; hf && hi == 9'h004 && ins == crd_pkg::INS_DEC |-> h2c_data <= 8'h44;
  endproperty
  a_declen: assert property (p_declen) else $error("decode chunk too long");
  c_start: cover property (c_end && ins == crd_pkg::INS_START);
  c_enc: cover property (c_end && ins == crd_pkg::INS_ENC);
  c_end_rsp: cover property (c_end && ins == crd_pkg::INS_END);
endmodule : crd_assertions
`default_nettype wire
